// >>> hw/jub_bridge.sv
// jtag user tile, clock configuration register and page memory behind axi4-lite
//
// Function
// - 81-bit register holds clock block configuration
// - configuration fields sit at fixed bit positions
// - reconfigure while running, no fabric reprogramming
// - eight 128-bit pages readable by core
// - dr flags high exactly in their states
// - instruction vector updates entering update_ir
// - user serial out reaches tdo for user codes
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module jub_bridge (
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    input  wire logic [jub_pkg::AXI_AW-1:0]      s_axi_awaddr,
    input  wire logic [2:0]                      s_axi_awprot,
    input  wire logic                            s_axi_awvalid,
    output      logic                            s_axi_awready,
    input  wire logic [jub_pkg::AXI_DW-1:0]      s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output      logic                            s_axi_wready,
    output      logic [1:0]                      s_axi_bresp,
    output      logic                            s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    input  wire logic [jub_pkg::AXI_AW-1:0]      s_axi_araddr,
    input  wire logic [2:0]                      s_axi_arprot,
    input  wire logic                            s_axi_arvalid,
    output      logic                            s_axi_arready,
    output      logic [jub_pkg::AXI_DW-1:0]      s_axi_rdata,
    output      logic [1:0]                      s_axi_rresp,
    output      logic                            s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    input  wire logic                            tck,
    input  wire logic                            tms,
    input  wire logic                            tdi,
    input  wire logic                            trst_n,
    output      logic                            tdo,
    output      logic                            tdo_oe,
    output      logic [jub_pkg::IR_W-1:0]        instr_vector,
    output      logic                            user_serial_in,
    output      logic                            user_jtag_clock,
    output      logic                            shift_dr_flag,
    output      logic                            capture_dr_flag,
    output      logic                            update_dr_flag,
    output      logic                            user_reset_n,
    input  wire logic                            user_serial_out,
    input  wire logic                            cfg_serial_in,
    input  wire logic                            cfg_shift_en,
    input  wire logic                            cfg_load,
    output      logic                            cfg_serial_out,
    output      logic [jub_pkg::CFG_W-1:0]       clk_cfg,
    input  wire logic [jub_pkg::ROM_AW-1:0]      rom_rd_addr,
    output      logic [jub_pkg::ROM_PAGE_W-1:0]  rom_rd_data
);

    localparam int BE_W = jub_pkg::ROM_PAGE_W / 8;

    // ------------------------------------------------------------
    // tap controller
    // ------------------------------------------------------------
    jub_pkg::jub_tap_t     tap_q;
    jub_pkg::jub_tap_t     next_tap_st;
    logic                  tck_q;
    logic [7:0]            ir_shift;
    logic                  bypass_q;
    logic                  tck_rise;
    logic                  tck_fall;
    logic                  user_code;

    // tck edges, pins taken as synchronous to aclk
    assign tck_rise    = tck & ~tck_q;
    assign tck_fall    = ~tck & tck_q;
    assign next_tap_st = !trst_n ? jub_pkg::TLR :
                         tck_rise ? jub_pkg::next_tap(tap_q, tms) : tap_q;
    assign user_code   = (instr_vector >= jub_pkg::USER_LO) &&
                         (instr_vector <= jub_pkg::USER_HI);

    // state and flags, flags decoded from next state so they match tap_q
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tck_q           <= 1'b0;
            tap_q           <= jub_pkg::TLR;
            shift_dr_flag   <= 1'b0;
            capture_dr_flag <= 1'b0;
            update_dr_flag  <= 1'b0;
            user_reset_n    <= 1'b0;
            user_jtag_clock <= 1'b0;
            user_serial_in  <= 1'b0;
        end else begin
            tck_q           <= tck;
            tap_q           <= next_tap_st;
            shift_dr_flag   <= (next_tap_st == jub_pkg::SH_DR);
            capture_dr_flag <= (next_tap_st == jub_pkg::CAP_DR);
            update_dr_flag  <= (next_tap_st == jub_pkg::UPD_DR);
            user_reset_n    <= (next_tap_st != jub_pkg::TLR);
            user_jtag_clock <= tck;
            user_serial_in  <= tdi;
        end
    end

    // instruction shift and user vector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ir_shift     <= jub_pkg::IR_RESET;
            instr_vector <= jub_pkg::IR_RESET;
            bypass_q     <= 1'b0;
        end else begin
            if (tck_rise && tap_q == jub_pkg::CAP_IR) ir_shift <= jub_pkg::IR_CAPTURE;
            if (tck_rise && tap_q == jub_pkg::SH_IR) ir_shift <= {tdi, ir_shift[7:1]};
            if (tck_rise && tap_q == jub_pkg::CAP_DR) bypass_q <= 1'b0;
            if (tck_rise && tap_q == jub_pkg::SH_DR) bypass_q <= tdi;
            if (tap_q == jub_pkg::TLR) begin
                instr_vector <= jub_pkg::IR_RESET;
            end else if (tck_rise && next_tap_st == jub_pkg::UPD_IR) begin
                instr_vector <= ir_shift;
            end
        end
    end

    // tdo changes on the falling tck edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= (tap_q == jub_pkg::SH_DR) || (tap_q == jub_pkg::SH_IR);
            if (tap_q == jub_pkg::SH_DR) begin
                tdo <= user_code ? user_serial_out : bypass_q;
            end else if (tap_q == jub_pkg::SH_IR) begin
                tdo <= ir_shift[0];
            end
        end
    end

    // ------------------------------------------------------------
    // clock configuration register
    // ------------------------------------------------------------
    logic [jub_pkg::CFG_W-1:0] cfg_shift;
    logic                      cfg_lock;
    logic                      prog_en;

    assign cfg_serial_out = cfg_shift[0];

    // shadow shifts from the core, active copy changes only on load
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_shift <= jub_pkg::CFG_RESET;
            clk_cfg   <= jub_pkg::CFG_RESET;
        end else begin
            if (cfg_shift_en) cfg_shift <= {cfg_serial_in, cfg_shift[jub_pkg::CFG_W-1:1]};
            if (cfg_load && !cfg_lock) clk_cfg <= cfg_shift;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic [7:0]            aw_addr_q;
    logic                  aw_full;
    logic [31:0]           w_data_q;
    logic [3:0]            w_strb_q;
    logic                  w_full;
    logic [jub_pkg::ROMA_W-1:0] rom_addr_q;
    logic                  do_write;
    logic                  w_map;
    logic                  r_map;
    logic [31:0]           rd_word;
    logic                  rom_we;
    logic [BE_W-1:0]       rom_be;

    // write decode
    assign do_write = aw_full && w_full && !s_axi_bvalid;
    assign w_map    = jub_pkg::hits(aw_addr_q, jub_pkg::OFF_CTRL) ||
                      jub_pkg::hits(aw_addr_q, jub_pkg::OFF_STATUS) ||
                      jub_pkg::hits(aw_addr_q, jub_pkg::OFF_CFG0) ||
                      jub_pkg::hits(aw_addr_q, jub_pkg::OFF_CFG1) ||
                      jub_pkg::hits(aw_addr_q, jub_pkg::OFF_CFG2) ||
                      jub_pkg::hits(aw_addr_q, jub_pkg::OFF_ROM_ADDR) ||
                      jub_pkg::hits(aw_addr_q, jub_pkg::OFF_ROM_DATA);
    assign rom_we   = do_write && prog_en && jub_pkg::hits(aw_addr_q, jub_pkg::OFF_ROM_DATA);
    assign rom_be   = BE_W'({{(BE_W-4){1'b0}}, w_strb_q} << {rom_addr_q[1:0], 2'h0});

    // read decode
    assign r_map   = jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_CTRL) ||
                     jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_STATUS) ||
                     jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_CFG0) ||
                     jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_CFG1) ||
                     jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_CFG2) ||
                     jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_ROM_ADDR) ||
                     jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_ROM_DATA);
    assign rd_word =
        jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_CTRL)   ? {30'h0, prog_en, cfg_lock} :
        jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_STATUS) ? {16'h0, instr_vector, 4'h0, tap_q} :
        jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_CFG0)   ? clk_cfg[31:0] :
        jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_CFG1)   ? clk_cfg[63:32] :
        jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_CFG2)   ? {15'h0, clk_cfg[80:64]} :
        jub_pkg::hits(s_axi_araddr, jub_pkg::OFF_ROM_ADDR) ? {27'h0, rom_addr_q} : 32'h0;

    // address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr_q     <= 8'h0;
            w_data_q      <= 32'h0;
            w_strb_q      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q     <= s_axi_awaddr;
                aw_full       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                w_full       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_full       <= 1'b0;
                w_full        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // write response and register updates
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= jub_pkg::RESP_OKAY;
            cfg_lock     <= 1'b0;
            prog_en      <= 1'b0;
            rom_addr_q   <= '0;
        end else begin
            if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_map ? jub_pkg::RESP_OKAY : jub_pkg::RESP_SLVERR;
                if (jub_pkg::hits(aw_addr_q, jub_pkg::OFF_CTRL) && w_strb_q[0]) begin
                    cfg_lock <= w_data_q[jub_pkg::CTRL_LOCK];
                    prog_en  <= w_data_q[jub_pkg::CTRL_PROG];
                end
                if (jub_pkg::hits(aw_addr_q, jub_pkg::OFF_ROM_ADDR) && w_strb_q[0]) begin
                    rom_addr_q <= w_data_q[jub_pkg::ROMA_W-1:0];
                end
            end
        end
    end

    // read channel, answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= jub_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= r_map ? rd_word : 32'h0;
            s_axi_rresp   <= r_map ? jub_pkg::RESP_OKAY : jub_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // page memory, core reads any page every cycle
    // ------------------------------------------------------------
    jub_page_mem #(
        .DATA_W (jub_pkg::ROM_PAGE_W),
        .DEPTH  (jub_pkg::ROM_PAGES),
        .ADDR_W (jub_pkg::ROM_AW)
    ) jub_page_mem_inst (
        .clk     (aclk),
        .rst_n   (aresetn),
        .wr_en   (rom_we),
        .wr_addr (rom_addr_q[jub_pkg::ROMA_W-1:2]),
        .wr_be   (rom_be),
        .wr_data ({4{w_data_q}}),
        .rd_addr (rom_rd_addr),
        .rd_data (rom_rd_data)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_shift_flag_state: assert property (shift_dr_flag == (tap_q == jub_pkg::SH_DR))
        else $error("shift flag disagrees with tap state");
    a_cap_flag_state: assert property (capture_dr_flag == (tap_q == jub_pkg::CAP_DR))
        else $error("capture flag disagrees with tap state");
    a_upd_flag_state: assert property (update_dr_flag == (tap_q == jub_pkg::UPD_DR))
        else $error("update flag disagrees with tap state");
    a_instr_update_only: assert property ($changed(instr_vector) |->
        (tap_q == jub_pkg::UPD_IR) || ($past(tap_q) == jub_pkg::TLR))
        else $error("instruction vector changed outside update_ir");
    a_instr_takes_ir: assert property ((tck_rise && next_tap_st == jub_pkg::UPD_IR)
        |=> instr_vector == $past(ir_shift))
        else $error("instruction vector missed the shifted code");
    a_tdo_user_path: assert property ((tck_fall && tap_q == jub_pkg::SH_DR && user_code)
        |=> tdo == $past(user_serial_out) && tdo_oe)
        else $error("user serial out not on tdo");
    a_tdo_bypass_path: assert property ((tck_fall && tap_q == jub_pkg::SH_DR && !user_code)
        |=> tdo == $past(bypass_q))
        else $error("tdo not bypass for non-user code");
    a_cfg_load_copy: assert property ((cfg_load && !cfg_lock) |=> clk_cfg == $past(cfg_shift))
        else $error("configuration load lost");
    a_cfg_hold_active: assert property (!(cfg_load && !cfg_lock) ##1 cfg_shift_en
        |-> $stable(clk_cfg))
        else $error("active configuration moved while shifting");
    a_cfg_shift_in: assert property (cfg_shift_en ##1 1'b1 |-> cfg_shift[80] == $past(cfg_serial_in))
        else $error("configuration bit not shifted in");

    c_user_instr: cover property (tck_rise && next_tap_st == jub_pkg::UPD_IR && ir_shift == jub_pkg::USER_LO);
    c_user_shift: cover property (shift_dr_flag && user_code ##[1:50] update_dr_flag);
    c_cfg_load: cover property (cfg_shift_en [*8] ##1 cfg_load);
    c_axi_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == jub_pkg::RESP_OKAY);

endmodule // jub_bridge

// >>> hw/jub_pkg.sv
// package: constants, field map and tap states of the jtag user data bridge
package jub_pkg;

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    localparam int         IR_W       = 8;
    localparam logic [7:0] IR_RESET   = 8'hff;  // bypass after test logic reset
    localparam logic [7:0] IR_CAPTURE = 8'h01;  // fixed pattern seen in shift_ir
    localparam logic [7:0] USER_LO    = 8'h10;  // first user code
    localparam logic [7:0] USER_HI    = 8'h7f;  // last user code

    // ------------------------------------------------------------
    // clock conditioning configuration map
    // ------------------------------------------------------------
    localparam int CFG_W             = 81;
    localparam int F_RESET_EN        = 80;
    localparam int F_DYN_SEL_C       = 79;
    localparam int F_DYN_SEL_B       = 78;
    localparam int F_DYN_SEL_A       = 77;
    localparam int F_OSC_RANGE_LSB   = 74;   // 3 bits
    localparam int F_STATIC_SEL_C    = 73;
    localparam int F_STATIC_SEL_B    = 72;
    localparam int F_STATIC_SEL_A    = 71;
    localparam int F_OUT_C_DLY_LSB   = 66;   // 5 bits
    localparam int F_OUT_B_DLY_LSB   = 61;   // 5 bits
    localparam int F_GLB_C_DLY_LSB   = 56;   // 5 bits
    localparam int F_GLB_B_DLY_LSB   = 51;   // 5 bits
    localparam int F_GLB_A_DLY_LSB   = 46;   // 5 bits
    localparam int F_EXTRA_DLY_SEL   = 45;
    localparam int F_FB_DLY_LSB      = 40;   // 5 bits
    localparam int F_FB_SRC_LSB      = 38;   // 2 bits
    localparam int F_OUT_C_MUX_LSB   = 35;   // 3 bits
    localparam int F_OUT_B_MUX_LSB   = 32;   // 3 bits
    localparam int F_OUT_A_MUX_LSB   = 29;   // 3 bits
    localparam int F_OUT_C_DIV_LSB   = 24;   // 5 bits
    localparam int F_OUT_B_DIV_LSB   = 19;   // 5 bits
    localparam int F_OUT_A_DIV_LSB   = 14;   // 5 bits
    localparam int F_FB_DIV_LSB      = 7;    // 7 bits
    localparam int F_IN_DIV_LSB      = 0;    // 7 bits
    localparam logic [CFG_W-1:0] CFG_RESET = 81'h0;

    // ------------------------------------------------------------
    // page memory
    // ------------------------------------------------------------
    localparam int ROM_PAGES  = 8;
    localparam int ROM_PAGE_W = 128;
    localparam int ROM_AW     = 3;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int         AXI_AW       = 8;
    localparam int         AXI_DW       = 32;
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_CFG0     = 8'h08;
    localparam logic [7:0] OFF_CFG1     = 8'h0c;
    localparam logic [7:0] OFF_CFG2     = 8'h10;
    localparam logic [7:0] OFF_ROM_ADDR = 8'h14;
    localparam logic [7:0] OFF_ROM_DATA = 8'h18;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    localparam int         CTRL_LOCK    = 0;     // core loads ignored while set
    localparam int         CTRL_PROG    = 1;     // page writes allowed while set
    localparam int         ROMA_W       = 5;     // [4:2] page, [1:0] word

    // ------------------------------------------------------------
    // tap controller
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } jub_tap_t;

    function automatic jub_tap_t next_tap(input jub_tap_t s, input logic tms);
        case (s)
            TLR:     next_tap = tms ? TLR    : RTI;
            RTI:     next_tap = tms ? SEL_DR : RTI;
            SEL_DR:  next_tap = tms ? SEL_IR : CAP_DR;
            CAP_DR:  next_tap = tms ? EX1_DR : SH_DR;
            SH_DR:   next_tap = tms ? EX1_DR : SH_DR;
            EX1_DR:  next_tap = tms ? UPD_DR : PA_DR;
            PA_DR:   next_tap = tms ? EX2_DR : PA_DR;
            EX2_DR:  next_tap = tms ? UPD_DR : SH_DR;
            UPD_DR:  next_tap = tms ? SEL_DR : RTI;
            SEL_IR:  next_tap = tms ? TLR    : CAP_IR;
            CAP_IR:  next_tap = tms ? EX1_IR : SH_IR;
            SH_IR:   next_tap = tms ? EX1_IR : SH_IR;
            EX1_IR:  next_tap = tms ? UPD_IR : PA_IR;
            PA_IR:   next_tap = tms ? EX2_IR : PA_IR;
            EX2_IR:  next_tap = tms ? UPD_IR : SH_IR;
            UPD_IR:  next_tap = tms ? SEL_DR : RTI;
            default: next_tap = TLR;
        endcase
    endfunction

    // word select of one register offset
    function automatic logic hits(input logic [7:0] addr, input logic [7:0] off);
        hits = (addr[7:2] == off[7:2]);
    endfunction

endpackage

// >>> hw/jub_page_mem.sv
// page memory with byte write enables and a registered read port
`timescale 1ns/1ps
module jub_page_mem #(
    parameter int DATA_W = 128,
    parameter int DEPTH  = 8,
    parameter int ADDR_W = 3
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  wr_en,
    input  wire logic [ADDR_W-1:0]     wr_addr,
    input  wire logic [DATA_W/8-1:0]   wr_be,
    input  wire logic [DATA_W-1:0]     wr_data,
    input  wire logic [ADDR_W-1:0]     rd_addr,
    output      logic [DATA_W-1:0]     rd_data
);

    logic [DATA_W-1:0] mem [DEPTH];

    // byte lane writes
    always_ff @(posedge clk) begin
        for (int b = 0; b < DATA_W/8; b++) begin
            if (wr_en && wr_be[b]) begin
                mem[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
            end
        end
    end

    // one page read every cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // jub_page_mem

// >>> sim/jub_host.sv
// jtag host model driving the test access port
`timescale 1ns/1ps
module jub_host (
    input  wire logic aclk,
    output      logic tck,
    output      logic tms,
    output      logic tdi
);
    // idle: clock low, tms high keeps the tap in reset
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one tck period, tck low four aclk and high three so the sampler sees it
    task automatic clk(input logic m, input logic d);
        tms <= m;
        tdi <= d;
        repeat (3) @(posedge aclk);
        tck <= 1'b1;
        repeat (3) @(posedge aclk);
        tck <= 1'b0;
        tdi <= ~d; // stale bit not left on the line
        @(posedge aclk);
    endtask
endmodule // jub_host

// >>> sim/jub_bridge_tb.sv
// self-checking testbench of the jtag user data bridge
`timescale 1ns/1ps
`define CHK(n,e,g) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module jub_bridge_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, q;
    logic [1:0] r;
    logic [80:0] pat = 81'h1_5a5a_c3c3_0f0f_9669_a55a;
    logic user_serial_out, cfg_serial_in, cfg_shift_en, cfg_load, fin, ka, kw, kr;
    logic [2:0] rom_rd_addr;
    wire logic tck, tms, tdi, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic s_axi_rvalid, tdo, shift_dr_flag, capture_dr_flag, update_dr_flag;
    wire logic tdo_oe, user_reset_n, user_serial_in, user_jtag_clock, cfg_serial_out;
    wire logic [127:0] rom_rd_data;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [7:0] instr_vector;
    wire logic [80:0] clk_cfg;
    int fail_count = 0;
    int n_compared = 0;
    int i;
    jub_host jub_host_inst (.aclk, .tck, .tms, .tdi);
    jub_bridge jub_bridge_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tck, .tms, .tdi,
        .trst_n(1'b1), .tdo, .tdo_oe, .instr_vector, .user_serial_in, .user_jtag_clock,
        .shift_dr_flag, .capture_dr_flag, .update_dr_flag, .user_reset_n, .user_serial_out,
        .cfg_serial_in, .cfg_shift_en, .cfg_load, .cfg_serial_out, .clk_cfg,
        .rom_rd_addr, .rom_rd_data);
    // clock, 10 ns period
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // one axi4-lite access; handshakes judged at the rising edge that takes them
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        fin = 1'b0;
        while (!fin) begin
            @(posedge aclk);
            ka = s_axi_awvalid && s_axi_awready;
            kw = s_axi_wvalid && s_axi_wready;
            kr = s_axi_arvalid && s_axi_arready;
            fin = w ? s_axi_bvalid : s_axi_rvalid;
            r = w ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            if (ka) s_axi_awvalid <= 1'b0;
            if (kw) s_axi_wvalid <= 1'b0;
            if (kr) s_axi_arvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // verdict and end of run
    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        #50000;
        fail_count++;
        stop_test();
    end
    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {user_serial_out, cfg_serial_in, cfg_shift_en, cfg_load, rom_rd_addr} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi(0, 8'h04, 0);
        `CHK("status", 32'h0000ff00, q)
        for (i = 0; i < 5; i++) jub_host_inst.clk(i inside {1, 2}, 1'b0);
        for (i = 0; i < 8; i++) jub_host_inst.clk(i == 7, i == 5);
        jub_host_inst.clk(1'b1, 1'b0);
        axi(0, 8'h04, 0);
        `CHK("status", 32'h0000200f, q)
        `CHK("user_reset_n", 1'b1, user_reset_n)
        `CHK("tdi copy", 1'b1, user_serial_in)
        `CHK("tck copy", 1'b0, user_jtag_clock)
        jub_host_inst.clk(1'b1, 1'b0);
        jub_host_inst.clk(1'b0, 1'b0);
        `CHK("capture", 1'b1, capture_dr_flag)
        user_serial_out <= 1'b1;
        jub_host_inst.clk(1'b0, 1'b0);
        repeat (3) @(posedge aclk);
        `CHK("shift", 1'b1, shift_dr_flag)
        `CHK("tdo", 1'b1, tdo)
        `CHK("tdo_oe", 1'b1, tdo_oe)
        user_serial_out <= 1'b0;
        jub_host_inst.clk(1'b0, 1'b0);
        repeat (3) @(posedge aclk);
        `CHK("tdo", 1'b0, tdo)
        jub_host_inst.clk(1'b1, 1'b0);
        `CHK("shift", 1'b0, shift_dr_flag)
        jub_host_inst.clk(1'b1, 1'b0);
        `CHK("update", 1'b1, update_dr_flag)
        for (i = 0; i < 81; i++) begin
            cfg_shift_en <= 1'b1;
            cfg_serial_in <= pat[i];
            @(posedge aclk);
        end
        cfg_shift_en <= 1'b0;
        cfg_load <= 1'b1;
        @(posedge aclk);
        cfg_load <= 1'b0;
        repeat (2) @(posedge aclk);
        `CHK("clk_cfg", pat, clk_cfg)
        `CHK("cfg_out", pat[0], cfg_serial_out)
        axi(0, 8'h08, 0);
        `CHK("cfg0", pat[31:0], q)
        axi(0, 8'h10, 0);
        `CHK("cfg2", {15'h0, pat[80:64]}, q)
        axi(1, 8'h40, 32'h1);
        `CHK("bresp", 2'h2, r)
        axi(0, 8'h40, 0);
        `CHK("rresp", 2'h2, r)
        axi(1, 8'h00, 32'h2);
        axi(1, 8'h14, 32'hd);
        axi(1, 8'h18, 32'hc0de_1234);
        `CHK("bresp", 2'h0, r)
        rom_rd_addr <= 3'h3;
        repeat (2) @(posedge aclk);
        `CHK("page", 32'hc0de_1234, rom_rd_data[63:32])
        stop_test();
    end
endmodule // jub_bridge_tb
